// ### design/oscen_ctrl.v
// Key-protected oscillator enable and stability status block with an AXI4-Lite slave.
`timescale 1ns/1ps
`include "oscen_map.vh"

// Notes on behaviour
// R1: A control write takes effect only when the write just before it put 0xCB14 in the key.
// R2: After the key is written, a write to any other address relocks the protection.
// R3: The 16-bit key register at 0xA0C resets to zero, so the block starts locked.
// R4: The control register at 0xA10 resets to 0x0003, internal oscillators on, crystal off.
// R5: Bit 10 reads one only while the crystal is enabled and has become stable.
// R6: Bit 9 reads one only while the fast internal oscillator is enabled and stable.
// R7: Bit 8 reads one only while the slow internal oscillator is enabled and stable.
// R8: Each stable flag latches the first settling after enable and ignores later loss.
// R9: Bit 2 enables the crystal, clear powers it down, reset value zero.
// R10: Bit 1 enables the fast internal oscillator, clear powers it down, reset value one.
// R11: Bit 0 enables the slow internal oscillator, clear powers it down, reset value one.
// R12: Software waits for a stable flag before using that oscillator as a clock.
// R13: Software sets crystal and fast internal enables before requesting a system reset.
// R14: Reserved control bits 15 to 11 and 7 to 3 read zero and ignore writes.
module oscen_ctrl #(
   parameter SETTLE_CYC = `OSCEN_SETTLE_CYC
) (
   // Clock and reset.
   input  wire        sys_clk,
   input  wire        arst_n,
   // AXI4-Lite write address.
   input  wire [11:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   // AXI4-Lite write data.
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   // AXI4-Lite write response.
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // AXI4-Lite read address.
   input  wire [11:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   // AXI4-Lite read data.
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // Oscillator analog controls and raw ready levels.
   output wire        crystalEnable,
   output wire        fastInternalEnable,
   output wire        slowInternalEnable,
   input  wire [2:0]  oscReadyRaw,
   // System reset request and interrupt.
   output reg         systemResetRequest,
   output wire        irq
);
   localparam CW = 16;
   // Last count of the settle counter; the counter is narrower than the parameter.
   localparam [31:0] SETTLE_LAST = SETTLE_CYC - 1;

   // Byte offsets of the mapped registers.
   localparam [11:0] OFS_KEY  = `OSCEN_OFS_KEY;
   localparam [11:0] OFS_CTRL = `OSCEN_OFS_CTRL;
   localparam [11:0] OFS_STAT = `OSCEN_OFS_IRQSTAT;
   localparam [11:0] OFS_MASK = `OSCEN_OFS_IRQMASK;
   localparam [11:0] OFS_REQ  = `OSCEN_OFS_REQ;

   // Word indices, taken from the offsets by dropping the byte lane bits.
   localparam [9:0]  IDX_KEY  = OFS_KEY[11:2];
   localparam [9:0]  IDX_CTRL = OFS_CTRL[11:2];
   localparam [9:0]  IDX_STAT = OFS_STAT[11:2];
   localparam [9:0]  IDX_MASK = OFS_MASK[11:2];
   localparam [9:0]  IDX_REQ  = OFS_REQ[11:2];

   // One-hot register selects; all zero marks an unmapped address.
   localparam [4:0]  SEL_NONE = 5'b00000;
   localparam [4:0]  SEL_KEY  = 5'b00001;
   localparam [4:0]  SEL_CTRL = 5'b00010;
   localparam [4:0]  SEL_STAT = 5'b00100;
   localparam [4:0]  SEL_MASK = 5'b01000;
   localparam [4:0]  SEL_REQ  = 5'b10000;

   reg  [11:0] awAddr_r;
   reg         awHave_r;
   reg  [31:0] wData_r;
   reg  [3:0]  wStrb_r;
   reg         wHave_r;
   reg  [15:0] key_r;
   reg         unlocked_r;
   reg  [2:0]  enable_r;
   reg  [2:0]  stable_r;
   reg  [2:0]  irqStat_r;
   reg  [2:0]  irqMask_r;
   reg  [CW-1:0] settleCnt_r [0:2];
   wire [2:0]  oscReady;
   wire        doWrite;
   wire [15:0] wLow;
   wire [2:0]  stableRise;
   wire [4:0]  wrSel;
   wire [4:0]  rdSel;
   reg  [2:0]  stablePrev_r;
   wire        stClr;
   integer     i;

   // Applies the byte strobes to a 16-bit register value.
   function [15:0] merge16;
      input [15:0] old;
      input [31:0] data;
      input [3:0]  strb;
      begin
         merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
      end
   endfunction

   // Decodes a byte address into a one-hot register select, shared by both channels.
   function [4:0] regSel;
      input [11:0] addr;
      begin
         case (addr[11:2])
            IDX_KEY:  regSel = SEL_KEY;
            IDX_CTRL: regSel = SEL_CTRL;
            IDX_STAT: regSel = SEL_STAT;
            IDX_MASK: regSel = SEL_MASK;
            IDX_REQ:  regSel = SEL_REQ;
            default:  regSel = SEL_NONE;
         endcase
      end
   endfunction

   assign wrSel = regSel(awAddr_r);
   assign rdSel = regSel(s_axi_araddr);

   oscen_sync #(.W(3)) uSync (
      .sys_clk (sys_clk),
      .arst_n  (arst_n),
      .dIn     (oscReadyRaw),
      .dOut    (oscReady)
   );

   assign s_axi_awready = !awHave_r && !s_axi_bvalid;
   assign s_axi_wready  = !wHave_r && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign doWrite       = awHave_r && wHave_r && !s_axi_bvalid;
   assign wLow          = merge16(16'h0000, wData_r, wStrb_r);

   // Write channel capture, in either order.
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         awAddr_r <= 12'h000;
         awHave_r <= 1'b0;
         wData_r  <= 32'h0000_0000;
         wStrb_r  <= 4'h0;
         wHave_r  <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awAddr_r <= s_axi_awaddr;
            awHave_r <= 1'b1;
         end else if (doWrite) begin
            awHave_r <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
            wHave_r <= 1'b1;
         end else if (doWrite) begin
            wHave_r <= 1'b0;
         end
      end
   end

   // Register writes, protection state and response.
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         key_r              <= `OSCEN_KEY_RST; // [R3]
         unlocked_r         <= 1'b0; // [R3]
         enable_r           <= `OSCEN_CTRL_RST; // [R4] [R9] [R10] [R11]
         irqMask_r          <= 3'h0;
         systemResetRequest <= 1'b0;
         s_axi_bvalid       <= 1'b0;
         s_axi_bresp        <= `OSCEN_RESP_OKAY;
      end else begin
         systemResetRequest <= 1'b0;
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= `OSCEN_RESP_OKAY;
            // Any write, control included, drops the unlock unless it puts the code in the key.
            unlocked_r   <= 1'b0; // [R2]
            case (wrSel)
               SEL_KEY: begin
                  key_r      <= merge16(key_r, wData_r, wStrb_r);
                  unlocked_r <= (merge16(key_r, wData_r, wStrb_r) == `OSCEN_UNLOCK_CODE); // [R1]
               end
               SEL_CTRL: begin
                  if (unlocked_r && wStrb_r[0]) begin
                     enable_r <= wData_r[2:0]; // [R1] [R9] [R10] [R11] [R14]
                  end
               end
               SEL_MASK: begin
                  if (wStrb_r[0]) begin
                     irqMask_r <= wData_r[2:0];
                  end
               end
               SEL_REQ: begin
                  systemResetRequest <= wLow[`OSCEN_BIT_RSTREQ]; // [R13]
               end
               SEL_STAT: begin
                  // Clearing is handled with the status bits themselves.
               end
               default: begin
                  s_axi_bresp <= `OSCEN_RESP_SLVERR;
               end
            endcase
         end
      end
   end

   assign crystalEnable      = enable_r[`OSCEN_BIT_XTAL_EN]; // [R9]
   assign fastInternalEnable = enable_r[`OSCEN_BIT_FAST_EN]; // [R10]
   assign slowInternalEnable = enable_r[`OSCEN_BIT_SLOW_EN]; // [R11]

   // Stability detection: settle count after enable, then latch until disable.
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         stable_r <= 3'h0;
         for (i = 0; i < 3; i = i + 1) begin
            settleCnt_r[i] <= {CW{1'b0}};
         end
      end else begin
         for (i = 0; i < 3; i = i + 1) begin
            if (!enable_r[i]) begin
               stable_r[i]    <= 1'b0; // [R5] [R6] [R7]
               settleCnt_r[i] <= {CW{1'b0}};
            end else if (!stable_r[i]) begin
               if (!oscReady[i]) begin
                  settleCnt_r[i] <= {CW{1'b0}};
               end else if (settleCnt_r[i] == SETTLE_LAST[CW-1:0]) begin
                  stable_r[i] <= 1'b1; // [R5] [R6] [R7] [R8]
               end else begin
                  settleCnt_r[i] <= settleCnt_r[i] + 16'h0001;
               end
            end
         end
      end
   end

   // A flag only rises on its first settling, so this edge marks one event per enable.
   assign stableRise = stable_r & ~stablePrev_r;

   // Sticky interrupt status, set on each first stabilisation, write one to clear.
   // A set and a clear in the same cycle leave the bit set, so no event is lost.
   assign stClr = doWrite && (wrSel == SEL_STAT) && wStrb_r[0];
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         stablePrev_r <= 3'h0;
         irqStat_r    <= 3'h0;
      end else begin
         stablePrev_r <= stable_r;
         irqStat_r    <= (irqStat_r & ~(stClr ? wData_r[2:0] : 3'h0))
                         | stableRise;
      end
   end
   assign irq = |(irqStat_r & irqMask_r);

   // Read channel; reserved bits read zero.
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `OSCEN_RESP_OKAY;
      end else begin
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `OSCEN_RESP_OKAY;
            s_axi_rdata  <= 32'h0000_0000;
            case (rdSel)
               SEL_KEY: begin
                  s_axi_rdata <= {16'h0000, key_r};
               end
               SEL_CTRL: begin
                  s_axi_rdata <= {21'h00_0000, stable_r, 5'h00, enable_r}; // [R14]
               end
               SEL_STAT: begin
                  s_axi_rdata <= {29'h0000_0000, irqStat_r};
               end
               SEL_MASK: begin
                  s_axi_rdata <= {29'h0000_0000, irqMask_r};
               end
               SEL_REQ: begin
                  // The request register is write only and reads as zero.
                  s_axi_rdata <= 32'h0000_0000;
               end
               default: begin
                  s_axi_rresp <= `OSCEN_RESP_SLVERR;
               end
            endcase
         end
      end
   end
endmodule

// ### design/oscen_map.vh
// Register map, field positions, reset values and timing counts of the oscillator control block.
`ifndef OSCEN_MAP_VH
`define OSCEN_MAP_VH
`define OSCEN_ADDR_W        12
`define OSCEN_OFS_KEY       12'hA0C
`define OSCEN_OFS_CTRL      12'hA10
`define OSCEN_OFS_IRQSTAT   12'hA14
`define OSCEN_OFS_IRQMASK   12'hA18
`define OSCEN_OFS_REQ       12'hA1C
`define OSCEN_UNLOCK_CODE   16'hCB14
`define OSCEN_KEY_RST       16'h0000
`define OSCEN_CTRL_RST      3'h3
`define OSCEN_BIT_SLOW_EN   0
`define OSCEN_BIT_FAST_EN   1
`define OSCEN_BIT_XTAL_EN   2
`define OSCEN_BIT_SLOW_OK   8
`define OSCEN_BIT_FAST_OK   9
`define OSCEN_BIT_XTAL_OK   10
`define OSCEN_BIT_RSTREQ    0
`define OSCEN_RESP_OKAY     2'h0
`define OSCEN_RESP_SLVERR   2'h2
`define OSCEN_SETTLE_NS     1000
`define OSCEN_CLK_MHZ       200
`define OSCEN_SETTLE_CYC    ((`OSCEN_SETTLE_NS * `OSCEN_CLK_MHZ + 999) / 1000)
`endif

// ### design/oscen_sync.v
// Two flip-flop synchroniser for a group of level inputs.
`timescale 1ns/1ps
module oscen_sync #(
   parameter W = 3
) (
   // Clock and reset.
   input  wire         sys_clk,
   input  wire         arst_n,
   // Data.
   input  wire [W-1:0] dIn,
   output wire [W-1:0] dOut
);
   reg [W-1:0] meta_r;
   reg [W-1:0] sync_r;
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_r <= {W{1'b0}};
         sync_r <= {W{1'b0}};
      end else begin
         meta_r <= dIn;
         sync_r <= meta_r;
      end
   end
   assign dOut = sync_r;
endmodule

// ### tb/oscen_ctrl_monitor.sv
// Concurrent checks on the port behaviour of the oscillator control block.
`timescale 1ns/1ps
module oscen_ctrl_monitor (
   // Clock and reset.
   input logic sys_clk,
   input logic arst_n,
   // Bus handshakes.
   input logic s_axi_awvalid,
   input logic s_axi_awready,
   input logic s_axi_bvalid,
   input logic s_axi_bready,
   input logic s_axi_arvalid,
   input logic s_axi_arready,
   input logic s_axi_rvalid,
   input logic s_axi_rready,
   // Oscillator side.
   input logic crystalEnable,
   input logic fastInternalEnable,
   input logic slowInternalEnable,
   input logic systemResetRequest
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   wire [2:0] enables = {crystalEnable, fastInternalEnable, slowInternalEnable};
   sequence s_rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence s_wr_recent;
      $past(s_axi_awvalid) || $past(s_axi_awvalid, 2) || $past(s_axi_awvalid, 3);
   endsequence
   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped before acceptance");
   a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("read data dropped before acceptance");
   a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
      else $error("read data late");
   a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while data pending");
   a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("write address taken while response pending");
   a_enable_reset: assert property ($rose(arst_n) |-> enables == 3'h3)
      else $error("enables wrong after reset");
   a_enable_by_write: assert property ($changed(enables) |-> s_wr_recent)
      else $error("enables changed without a write");
   a_reset_pulse: assert property (systemResetRequest |-> s_wr_recent ##1 !systemResetRequest)
      else $error("reset request not a single pulse after a write");
endmodule

// ### tb/oscen_ctrl_test.sv
// Self-checking bench for the oscillator control block.
`timescale 1ns/1ps
`include "oscen_map.vh"
module oscen_ctrl_test;
   localparam [11:0] K = `OSCEN_OFS_KEY;
   localparam [11:0] C = `OSCEN_OFS_CTRL;
   localparam [11:0] ST = `OSCEN_OFS_IRQSTAT;
   localparam [11:0] MK = `OSCEN_OFS_IRQMASK;
   localparam [31:0] CODE = 32'h0000_cb14;
   logic        sys_clk, arst_n, irq, systemResetRequest;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic [2:0]  oscReadyRaw;
   logic        crystalEnable, fastInternalEnable, slowInternalEnable;
   int          failCount, numChecks, cyc, pulses;
   oscen_ctrl #(.SETTLE_CYC(4)) oscen_ctrl_i (.sys_clk, .arst_n, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .crystalEnable, .fastInternalEnable, .slowInternalEnable,
      .oscReadyRaw, .systemResetRequest, .irq);
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      numChecks++;
      if (seen !== exp) begin
         failCount++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1);
      rs = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1);
      rd = s_axi_rdata;
      s_axi_rready <= 1'h0;
      check(rd, exp);
   endtask
   task endOfTest;
      $display("checks %0d, mismatches %0d", numChecks, failCount);
      if (failCount == 0 && numChecks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      sys_clk = 1'h0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (systemResetRequest === 1'h1) pulses++;
      if (cyc == 3000) begin
         failCount++;
         endOfTest;
      end
   end
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      s_axi_awaddr = 12'h000;
      s_axi_araddr = 12'h000;
      s_axi_wdata = 32'h0000_0000;
      oscReadyRaw = 3'h0;
      arst_n = 1'h0;
      repeat (6) @(posedge sys_clk);
      arst_n <= 1'h1;
      rdchk(K, 32'h0000_0000);
      rdchk(C, 32'h0000_0003);
      check({crystalEnable, fastInternalEnable, slowInternalEnable}, 32'h0000_0003);
      wr(C, 32'h0000_0007);
      rdchk(C, 32'h0000_0003);
      wr(K, CODE);
      wr(C, 32'h0000_0007);
      rdchk(C, 32'h0000_0007);
      check({crystalEnable, fastInternalEnable, slowInternalEnable}, 32'h0000_0007);
      oscReadyRaw <= 3'h7;
      repeat (20) @(posedge sys_clk);
      rdchk(C, 32'h0000_0707);
      oscReadyRaw <= 3'h0;
      repeat (20) @(posedge sys_clk);
      rdchk(C, 32'h0000_0707);
      rdchk(ST, 32'h0000_0007);
      check(irq, 1'h0);
      // Unlocking and then writing the mask must relock the control register.
      wr(K, CODE);
      wr(MK, 32'h0000_0001);
      wr(C, 32'h0000_0000);
      rdchk(C, 32'h0000_0707);
      check(irq, 1'h1);
      wr(ST, 32'h0000_0001);
      @(posedge sys_clk);
      check(irq, 1'h0);
      wr(K, CODE);
      wr(C, 32'h0000_fffa);
      rdchk(C, 32'h0000_0202);
      check({crystalEnable, fastInternalEnable, slowInternalEnable}, 32'h0000_0002);
      wr(12'ha00, 32'h0000_0000);
      check(rs, `OSCEN_RESP_SLVERR);
      // Both fast clock sources are enabled before the system reset request.
      wr(K, CODE);
      wr(C, 32'h0000_0007);
      wr(`OSCEN_OFS_REQ, 32'h0000_0001);
      repeat (2) @(posedge sys_clk);
      check(pulses, 32'h0000_0001);
      endOfTest;
   end
endmodule
bind oscen_ctrl oscen_ctrl_monitor mon_i (.sys_clk, .arst_n, .s_axi_awvalid, .s_axi_awready,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .s_axi_rready, .crystalEnable, .fastInternalEnable, .slowInternalEnable,
   .systemResetRequest);
